/* verilog/preset_table_command_unit.sv */
// preset table command unit: apb registers, command sequencer and table ram
//
// Contract
// - clear edge erases selected output's whole table
// - commands span cycles, end success or error
// - error code stays readable after error
// - edit edge overwrites exactly one entry
// - entry types 0 to 5, above is invalid
// - pulse time kept only for pulse types
// - pulse time is milliseconds, 0 to 65535
// - preset count accepted up to 2147434528
// - many edits per reload; combined edit reloads
// - cleared table never switches at old counts
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "preset_table_regs.svh"
module preset_table_command_unit
  import preset_table_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  output logic             profile_reload_o,
  output logic      [1:0]  reload_output_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  cmd_state_t                state;
  cmd_state_t                next_state;
  logic [`CMD_WIDTH-1:0]     cmd_bits;
  logic [`CMD_WIDTH-1:0]     cmd_prev;
  logic [1:0]                sel_output;
  logic [7:0]                sel_module;
  logic [7:0]                sel_table;
  logic [7:0]                sel_entry;
  logic [15:0]               entry_type;
  logic [15:0]               pulse_time;
  logic [31:0]               preset_count;
  logic                      configured;
  logic [7:0]                module_number;
  logic                      success;
  logic                      error;
  logic [7:0]                error_code;
  logic [7:0]                err_report;
  logic [`IRQ_WIDTH-1:0]     irq_status;
  logic [`IRQ_WIDTH-1:0]     irq_enable;
  logic                      op_clear;
  logic                      op_reload;
  logic                      fail;
  logic [9:0]                clr_cnt;
  logic [31:0]               rd_data;
  preset_word_t              ram_rdata;
  preset_word_t              ram_wdata;
  logic [11:0]               ram_waddr;
  logic [11:0]               ram_raddr;
  logic                      ram_we;
  logic [7:0]                chk_err;
  logic [15:0]               pulse_eff;
  logic [`CMD_WIDTH-1:0]     cmd_edge;
  logic                      idle;
  logic                      start_clear;
  logic                      start_edit;
  logic                      start;
  logic                      wr_en;
  logic                      rd_setup;
  logic                      addr_mapped;
  logic [`IRQ_WIDTH-1:0]     irq_set;
  logic [`IRQ_WIDTH-1:0]     irq_clr;

  // true when the bus address selects the given register
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ****************************************************************
  // apb slave: zero wait states, error on unmapped addresses
  // ****************************************************************
  assign wr_en       = psel_i & penable_i & pwrite_i;
  assign rd_setup    = psel_i & ~penable_i & ~pwrite_i;
  assign pready_o    = 1'b1;
  assign addr_mapped = hit(paddr_i, `OFS_CMD) | hit(paddr_i, `OFS_SELECT) |
                       hit(paddr_i, `OFS_ENTRY) | hit(paddr_i, `OFS_COUNT) |
                       hit(paddr_i, `OFS_STATUS) | hit(paddr_i, `OFS_ERR_CODE) |
                       hit(paddr_i, `OFS_IRQ_STATUS) | hit(paddr_i, `OFS_IRQ_CLEAR) |
                       hit(paddr_i, `OFS_IRQ_ENABLE) | hit(paddr_i, `OFS_CONFIG) |
                       hit(paddr_i, `OFS_RB_COUNT) | hit(paddr_i, `OFS_RB_ENTRY) |
                       hit(paddr_i, `OFS_ERR_REPORT);
  assign pslverr_o   = psel_i & penable_i & ~addr_mapped;

  // read selection; write-only and unmapped words read as zero
  always_comb begin
    case (paddr_i)
      `OFS_CMD:        rd_data = {28'h0000000, cmd_bits};
      `OFS_SELECT:     rd_data = {sel_entry, sel_table, sel_module, 6'h00, sel_output};
      `OFS_ENTRY:      rd_data = {pulse_time, entry_type};
      `OFS_COUNT:      rd_data = preset_count;
      `OFS_STATUS:     rd_data = {28'h0000000, configured, error, success, ~idle};
      `OFS_ERR_CODE:   rd_data = {24'h000000, error_code};
      `OFS_IRQ_STATUS: rd_data = {30'h0, irq_status};
      `OFS_IRQ_ENABLE: rd_data = {30'h0, irq_enable};
      `OFS_CONFIG:     rd_data = {23'h0, configured, module_number};
      `OFS_RB_COUNT:   rd_data = ram_rdata[31:0];
      `OFS_RB_ENTRY:   rd_data = {12'h000, ram_rdata[51:32]};
      `OFS_ERR_REPORT: rd_data = {24'h000000, err_report};
      default:         rd_data = `WORD_RESET;
    endcase
  end

  // read data captured in the setup phase, valid through the access phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= `WORD_RESET;
    end else if (rd_setup) begin
      prdata_o <= rd_data;
    end
  end

  // software-written command parameters and interrupt enables
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_bits     <= `CMD_RESET;
      sel_output   <= 2'h0;
      sel_module   <= `BYTE_RESET;
      sel_table    <= `BYTE_RESET;
      sel_entry    <= `BYTE_RESET;
      entry_type   <= `HALF_RESET;
      pulse_time   <= `HALF_RESET;
      preset_count <= `WORD_RESET;
      irq_enable   <= `IRQ_RESET;
    end else if (wr_en) begin
      if (hit(paddr_i, `OFS_CMD)) begin
        cmd_bits <= pwdata_i[`CMD_WIDTH-1:0];
      end
      if (hit(paddr_i, `OFS_SELECT)) begin
        sel_output <= pwdata_i[1:0];
        sel_module <= pwdata_i[15:8];
        sel_table  <= pwdata_i[23:16];
        sel_entry  <= pwdata_i[31:24];
      end
      if (hit(paddr_i, `OFS_ENTRY)) begin
        entry_type <= pwdata_i[15:0];
        pulse_time <= pwdata_i[31:16];
      end
      if (hit(paddr_i, `OFS_COUNT)) begin
        preset_count <= pwdata_i;
      end
      if (hit(paddr_i, `OFS_IRQ_ENABLE)) begin
        irq_enable <= pwdata_i[`IRQ_WIDTH-1:0];
      end
    end
  end

  // module configuration: number and the configured mark
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      configured    <= 1'b0;
      module_number <= `BYTE_RESET;
    end else if (wr_en && hit(paddr_i, `OFS_CONFIG)) begin
      configured    <= pwdata_i[`CFG_VALID_BIT];
      module_number <= pwdata_i[7:0];
    end
  end

  // ****************************************************************
  // command edge detection
  // ****************************************************************
  assign cmd_edge    = cmd_bits & ~cmd_prev;
  assign idle        = (state == ST_IDLE);
  // clear, edit and reload edges that arrive while a command runs are dropped
  assign start_clear = idle & cmd_edge[`CMD_CLEAR_BIT];
  assign start_edit  = idle & ~cmd_edge[`CMD_CLEAR_BIT] &
                       (cmd_edge[`CMD_EDIT_BIT] | cmd_edge[`CMD_RELOAD_BIT]);
  assign start       = start_clear | start_edit;

  // previous command bits and the error report snapshot
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_prev   <= `CMD_RESET;
      err_report <= `BYTE_RESET;
    end else begin
      cmd_prev <= cmd_bits;
      if (cmd_edge[`CMD_RDERR_BIT]) begin
        err_report <= error_code;
      end
    end
  end

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  entry_check u_check (
    .clear_mode_i (op_clear),
    .configured_i (configured),
    .own_number_i (module_number),
    .module_i     (sel_module),
    .table_i      (sel_table),
    .type_i       (entry_type),
    .pulse_i      (pulse_time),
    .count_i      (preset_count),
    .err_o        (chk_err),
    .pulse_eff_o  (pulse_eff)
  );

  // next state: check, then clear loop or single write, then done
  always_comb begin
    case (state)
      ST_IDLE:  next_state = start ? ST_CHECK : ST_IDLE;
      ST_CHECK: next_state = (chk_err != `ERR_NONE) ? ST_DONE :
                             op_clear ? ST_CLEAR : ST_WRITE;
      ST_CLEAR: next_state = (clr_cnt == `CLEAR_LAST) ? ST_DONE : ST_CLEAR;
      ST_WRITE: next_state = ST_DONE;
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // state, operation marks and clear counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state     <= ST_IDLE;
      op_clear  <= 1'b0;
      op_reload <= 1'b0;
      clr_cnt   <= 10'h000;
    end else begin
      state <= next_state;
      if (start) begin
        op_clear  <= start_clear;
        op_reload <= start_edit & cmd_edge[`CMD_RELOAD_BIT];
        clr_cnt   <= 10'h000;
      end else if (state == ST_CLEAR) begin
        clr_cnt <= clr_cnt + 10'h001;
      end
    end
  end

  // outcome flags: cleared at start, exactly one set at done
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      success    <= 1'b0;
      error      <= 1'b0;
      fail       <= 1'b0;
      error_code <= `ERR_NONE;
    end else begin
      if (start) begin
        success <= 1'b0;
        error   <= 1'b0;
      end
      if (state == ST_CHECK) begin
        fail <= (chk_err != `ERR_NONE);
        if (chk_err != `ERR_NONE) begin
          error_code <= chk_err;
        end
      end
      if (state == ST_DONE) begin
        success <= ~fail;
        error   <= fail;
      end
    end
  end

  // ****************************************************************
  // table memory access
  // ****************************************************************
  // clear writes blank words over every table of the output
  assign ram_we    = (state == ST_CLEAR) | (state == ST_WRITE);
  assign ram_waddr = (state == ST_CLEAR) ? {sel_output, clr_cnt} :
                     {sel_output, sel_table[`TABLE_BITS-1:0], sel_entry};
  assign ram_wdata = (state == ST_CLEAR) ? preset_word_t'(0) :
                     {1'b1, entry_type[2:0], pulse_eff, preset_count};
  assign ram_raddr = {sel_output, sel_table[`TABLE_BITS-1:0], sel_entry};

  preset_ram u_ram (
    .clk_i   (clk_i),
    .we_i    (ram_we),
    .waddr_i (ram_waddr),
    .wdata_i (ram_wdata),
    .raddr_i (ram_raddr),
    .rdata_o (ram_rdata)
  );

  // reload request after a combined edit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      profile_reload_o <= 1'b0;
      reload_output_o  <= 2'h0;
    end else begin
      profile_reload_o <= (state == ST_WRITE) & op_reload;
      if ((state == ST_WRITE) && op_reload) begin
        reload_output_o <= sel_output;
      end
    end
  end

  // ****************************************************************
  // interrupts: sticky events, set wins over clear
  // ****************************************************************
  assign irq_set = (state == ST_DONE) ? {fail, ~fail} : `IRQ_RESET;
  assign irq_clr = (wr_en && hit(paddr_i, `OFS_IRQ_CLEAR)) ?
                   pwdata_i[`IRQ_WIDTH-1:0] : `IRQ_RESET;
  assign irq_o   = |(irq_status & irq_enable);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status <= `IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  flags_exclusive_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i) !(success && error))
    else $error("success and error set together");

  clear_finish_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == ST_CLEAR && clr_cnt == `CLEAR_LAST) |=> state == ST_DONE ##1 success)
    else $error("clear did not finish with success");

  clear_blank_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == ST_CLEAR) |-> ram_we && !ram_wdata[51] && ram_waddr[11:10] == sel_output)
    else $error("clear wrote a live entry");

  busy_ignore_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (!idle && |cmd_edge) |=> $stable(op_clear) && $stable(op_reload))
    else $error("command accepted while busy");

  bad_type_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == ST_CHECK && !op_clear && configured && sel_module == module_number &&
     sel_table < `TABLE_COUNT && entry_type > `TYPE_RST_COUNT)
    |=> !ram_we ##1 error && error_code == `ERR_BAD_TYPE)
    else $error("invalid entry type not refused");

  pulse_mask_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == ST_WRITE && entry_type != `TYPE_PULSE_ON && entry_type != `TYPE_PULSE_OFF)
    |-> ram_wdata[47:32] == 16'h0000)
    else $error("pulse time kept for non pulse type");

  count_limit_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == ST_WRITE) |-> ram_wdata[31:0] <= `COUNT_MAX)
    else $error("preset count above limit written");

  single_write_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == ST_CHECK && !op_clear && chk_err == `ERR_NONE)
    |=> ram_we ##1 !ram_we ##1 success)
    else $error("edit did not write exactly one entry");

  reload_pulse_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == ST_WRITE) |=> profile_reload_o == $past(op_reload) ##1 !profile_reload_o)
    else $error("reload request wrong after edit");

  error_kept_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    error |-> error_code != `ERR_NONE)
    else $error("error flag without error code");

  irq_sticky_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (state == ST_DONE && fail) |=> irq_status[`IRQ_ERR_BIT])
    else $error("error event not latched");

endmodule

/* verilog/preset_table_regs.svh */
// register offsets, field positions, reset values and codes of the preset table unit
`ifndef PRESET_TABLE_REGS_SVH
`define PRESET_TABLE_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CMD        8'h00
`define OFS_SELECT     8'h04
`define OFS_ENTRY      8'h08
`define OFS_COUNT      8'h0c
`define OFS_STATUS     8'h10
`define OFS_ERR_CODE   8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_CLEAR  8'h1c
`define OFS_IRQ_ENABLE 8'h20
`define OFS_CONFIG     8'h24
`define OFS_RB_COUNT   8'h28
`define OFS_RB_ENTRY   8'h2c
`define OFS_ERR_REPORT 8'h30

// ****************************************************************
// field positions
// ****************************************************************
`define CMD_CLEAR_BIT   0
`define CMD_EDIT_BIT    1
`define CMD_RELOAD_BIT  2
`define CMD_RDERR_BIT   3
`define CMD_WIDTH       4
`define ST_BUSY_BIT     0
`define ST_SUCCESS_BIT  1
`define ST_ERROR_BIT    2
`define ST_CONFIG_BIT   3
`define IRQ_OK_BIT      0
`define IRQ_ERR_BIT     1
`define IRQ_WIDTH       2
`define CFG_VALID_BIT   8

// ****************************************************************
// reset values
// ****************************************************************
`define CMD_RESET      4'h0
`define IRQ_RESET      2'h0
`define WORD_RESET     32'h0000_0000
`define BYTE_RESET     8'h00
`define HALF_RESET     16'h0000

// ****************************************************************
// entry types, limits and error codes
// ****************************************************************
`define TYPE_SET        16'h0000
`define TYPE_RESET      16'h0001
`define TYPE_PULSE_ON   16'h0002
`define TYPE_PULSE_OFF  16'h0003
`define TYPE_TOGGLE     16'h0004
`define TYPE_RST_COUNT  16'h0005
`define COUNT_MAX       32'h7fff_4020
`define TABLE_COUNT     8'h04
`define TABLE_BITS      2
`define CLEAR_LAST      10'h3ff
`define ERR_NONE        8'h00
`define ERR_NOT_CONFIG  8'h01
`define ERR_BAD_MODULE  8'h02
`define ERR_BAD_TABLE   8'h03
`define ERR_BAD_TYPE    8'h04
`define ERR_BAD_COUNT   8'h05

`endif

/* verilog/preset_table_pkg.sv */
// types shared by the preset table unit
package preset_table_pkg;

  // command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_CLEAR = 3'b010,
    ST_WRITE = 3'b011,
    ST_DONE  = 3'b100
  } cmd_state_t;

  // stored entry: valid, type, pulse time, preset count
  typedef logic [51:0] preset_word_t;

endpackage

/* verilog/preset_ram.sv */
// preset table memory with registered read data
`timescale 1ns/1ps
module preset_ram
  import preset_table_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         we_i,
  input  wire logic [11:0]  waddr_i,
  input  wire preset_word_t wdata_i,
  input  wire logic [11:0]  raddr_i,
  output preset_word_t      rdata_o
);

  preset_word_t mem [0:4095];

  // write port and registered read port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

/* verilog/entry_check.sv */
// validation of a table command's fields and masking of the pulse time
`timescale 1ns/1ps
`include "preset_table_regs.svh"
module entry_check
  import preset_table_pkg::*;
(
  input  wire logic        clear_mode_i,
  input  wire logic        configured_i,
  input  wire logic [7:0]  own_number_i,
  input  wire logic [7:0]  module_i,
  input  wire logic [7:0]  table_i,
  input  wire logic [15:0] type_i,
  input  wire logic [15:0] pulse_i,
  input  wire logic [31:0] count_i,
  output logic      [7:0]  err_o,
  output logic      [15:0] pulse_eff_o
);

  logic uses_pulse;

  // only the two pulse types keep their pulse time, in milliseconds
  assign uses_pulse  = (type_i == `TYPE_PULSE_ON) | (type_i == `TYPE_PULSE_OFF);
  assign pulse_eff_o = uses_pulse ? pulse_i : `HALF_RESET;

  // first failing check wins; a clear only needs config and module number
  assign err_o = !configured_i               ? `ERR_NOT_CONFIG :
                 (module_i != own_number_i)  ? `ERR_BAD_MODULE :
                 clear_mode_i                ? `ERR_NONE       :
                 (table_i >= `TABLE_COUNT)   ? `ERR_BAD_TABLE  :
                 (type_i > `TYPE_RST_COUNT)  ? `ERR_BAD_TYPE   :
                 (count_i > `COUNT_MAX)      ? `ERR_BAD_COUNT  :
                                               `ERR_NONE;

endmodule

/* sim/plc_master.sv */
// controller side model: apb master with bounded waits
`timescale 1ns/1ps
module plc_master (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o
);
  logic hung;
  logic last_err;

  // ****************************************************************
  // bus idle at time zero
  // ****************************************************************
  initial begin
    hung      = 1'b0;
    last_err  = 1'b0;
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0000_0000;
  end

  // one transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    psel_o    <= 1'b1;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 50);
    if (pready_i !== 1'b1) hung = 1'b1;
    q         = prdata_i;
    last_err  = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;  // released lines must not keep the last value
    pwdata_o  <= ~d;
  endtask
endmodule

/* sim/preset_table_command_unit_test.sv */
// self-checking bench of the preset table command unit
`timescale 1ns/1ps
`include "preset_table_regs.svh"
module preset_table_command_unit_test;
  logic        clk_i;
  logic        arst_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        reload;
  logic [1:0]  reload_out;
  int          error_cnt;
  int          num_checks;
  int          reloads;

  // ****************************************************************
  // clock, design and controller model
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  preset_table_command_unit uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
    .profile_reload_o(reload), .reload_output_o(reload_out));

  plc_master apb (.clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));

  // counts reload pulses
  always @(posedge clk_i) begin
    if (reload === 1'b1) reloads <= reloads + 1;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic results;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus transfer; a hung bus counts as a mismatch and ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    apb.xfer(w, a, d, q);
    if (apb.hung) begin
      chk(32'h0000_0000, 32'h0000_0001);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge clk_i);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // poll status until success or error is flagged
  task automatic wait_done(input logic [31:0] st);
    logic [31:0] q;
    int n;
    repeat (2) @(posedge clk_i);
    n = 0;
    do begin
      bus(1'b0, `OFS_STATUS, 32'h0000_0000, q);
      n++;
    end while (q[2:1] === 2'b00 && n < 600);
    chk(q, st);
    if (q[2:1] === 2'b00) results();  // timed out: counted above, report now
  endtask

  task automatic edit(input logic [1:0] o, input logic [7:0] m, t, e,
                      input logic [15:0] ty, input logic [31:0] cnt,
                      input logic [3:0] c, input logic [31:0] st);
    wr(`OFS_SELECT, {e, t, m, 6'h00, o});
    wr(`OFS_ENTRY, {16'hffff, ty});
    wr(`OFS_COUNT, cnt);
    wr(`OFS_CMD, 32'h0000_0000);
    wr(`OFS_CMD, {28'h0, c});
    wait_done(st);  // parameters left alone until done
  endtask

  task automatic peek(input logic [1:0] o, input logic [7:0] t, e,
                      input logic [31:0] ent, cnt);
    wr(`OFS_SELECT, {e, t, 8'h5a, 6'h00, o});
    repeat (2) @(posedge clk_i);
    rd_chk(`OFS_RB_ENTRY, ent);
    rd_chk(`OFS_RB_COUNT, cnt);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    arst_n_i   = 1'b0;
    error_cnt  = 0;
    num_checks = 0;
    reloads    = 0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_chk(`OFS_STATUS, 32'h0000_0000);
    chk({31'h0, apb.last_err}, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    chk({31'h0, apb.last_err}, 32'h0000_0001);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0003);
    edit(2'h0, 8'h5a, 8'h00, 8'h00, `TYPE_SET, 32'h14, 4'h2, 32'h4);
    rd_chk(`OFS_ERR_CODE, 32'h0000_0001);
    chk_irq(1'b1);
    wr(`OFS_IRQ_CLEAR, 32'h0000_0002);
    chk_irq(1'b0);
    wr(`OFS_CONFIG, 32'h0000_015a);
    for (int i = 0; i < 7; i++) begin
      edit(2'h1, 8'h5a, 8'h02, i[7:0], i[15:0], 32'h0000_03e8 + i, 4'h2,
           (i < 6) ? 32'ha : 32'hc);
      if (i < 6) peek(2'h1, 8'h02, i[7:0], {12'h000, 1'b1, i[2:0],
           (i == 2 || i == 3) ? 16'hffff : 16'h0000}, 32'h0000_03e8 + i);
    end
    rd_chk(`OFS_ERR_CODE, 32'h0000_0004);
    edit(2'h1, 8'h5a, 8'h03, 8'hff, `TYPE_SET, `COUNT_MAX, 4'h2, 32'ha);
    edit(2'h1, 8'h5a, 8'h03, 8'hff, `TYPE_SET, `COUNT_MAX + 1, 4'h2, 32'hc);
    rd_chk(`OFS_ERR_CODE, 32'h0000_0005);
    peek(2'h1, 8'h03, 8'hff, 32'h0008_0000, `COUNT_MAX);
    edit(2'h1, 8'h5a, 8'h04, 8'h00, `TYPE_SET, 32'h1, 4'h2, 32'hc);
    rd_chk(`OFS_ERR_CODE, 32'h0000_0003);
    edit(2'h1, 8'h5b, 8'h00, 8'h00, `TYPE_SET, 32'h1, 4'h2, 32'hc);
    rd_chk(`OFS_ERR_CODE, 32'h0000_0002);
    wr(`OFS_CMD, 32'h0000_0000);
    wr(`OFS_CMD, 32'h0000_0008);
    repeat (3) @(posedge clk_i);
    rd_chk(`OFS_ERR_REPORT, 32'h0000_0002);
    edit(2'h0, 8'h5a, 8'h00, 8'h00, `TYPE_TOGGLE, 32'h7, 4'h2, 32'ha);
    chk(reloads, 0);
    wr(`OFS_SELECT, 32'h0002_5a01);
    wr(`OFS_CMD, 32'h0000_0000);
    wr(`OFS_CMD, 32'h0000_0001);
    wr(`OFS_CMD, 32'h0000_0003);
    wait_done(32'ha);
    peek(2'h1, 8'h02, 8'h00, 32'h0, 32'h0);
    peek(2'h1, 8'h03, 8'hff, 32'h0, 32'h0);
    peek(2'h0, 8'h00, 8'h00, 32'h000c_0000, 32'h7);
    edit(2'h2, 8'h5a, 8'h01, 8'h01, `TYPE_RESET, 32'h1e, 4'h4, 32'ha);
    chk(reloads, 1);
    chk({30'h0, reload_out}, 32'h0000_0002);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0000);
    chk_irq(1'b0);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0001);
    chk_irq(1'b1);
    wr(`OFS_IRQ_CLEAR, 32'h0000_0003);
    rd_chk(`OFS_IRQ_STATUS, 32'h0000_0000);
    chk_irq(1'b0);
    results();
  end
endmodule
